// ### logic/sfcc_crc_if.sv
// control and result signals of one serial crc engine
// assumes a single clock domain shared by controller and engine
interface sfcc_crc_if;
    logic load;
    logic [7:0] seed;
    logic shift;
    logic din;
    logic mode4;
    logic [7:0] crc;

    modport eng (input load, input seed, input shift, input din, input mode4, output crc);
    modport ctl (output load, output seed, output shift, output din, output mode4, input crc);
endinterface : sfcc_crc_if

// ### logic/sfcc_crc_serial.sv
// serial non-direct crc engine, 8-bit or 4-bit, one bit per shift
// assumes load and shift are never raised in the same cycle
module sfcc_crc_serial #(
    parameter logic [3:0] CRC4_POLY = sfcc_pkg::CRC4_POLY_DEF
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    sfcc_crc_if.eng crc_if
);
    import sfcc_pkg::*;

    logic [7:0] crc;
    logic [7:0] next_crc8;
    logic [3:0] next_crc4;
    logic [7:0] next_crc;

    // ----------------------------------------------------------------
    // next state: bit rotates into the lsb, top bit folds the polynomial
    // ----------------------------------------------------------------
    assign next_crc8 = {crc[6:0], crc_if.din} ^ (crc[7] ? CRC8_POLY : 8'h00);
    assign next_crc4 = {crc[2:0], crc_if.din} ^ (crc[3] ? CRC4_POLY : 4'h0);
    // upper nibble held at zero in 4-bit mode so a zero test covers both
    assign next_crc = crc_if.mode4 ? {4'h0, next_crc4} : next_crc8;

    // shift register
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            crc <= CRC_RESET;
        else if (crc_if.load)
            crc <= crc_if.seed;
        else if (crc_if.shift)
            crc <= next_crc;
    end

    assign crc_if.crc = crc;
endmodule : sfcc_crc_serial

// ### logic/sfcc_pkg.sv
// constants, field layout and helpers for the spi frame crc checker
// assumes 32-bit frames shifted msb first, one bit per accepted strobe
package sfcc_pkg;

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
    localparam logic [4:0] LAST_BIT_IDX = 5'h1F;
    localparam logic [4:0] LAST_STEP = 5'h1F;
    // message bits ahead of the crc field in each mode
    localparam logic [4:0] MSG_LEN_CRC8 = 5'h18;
    localparam logic [4:0] MSG_LEN_CRC4 = 5'h1C;

    // ----------------------------------------------------------------
    // register-access field positions
    // ----------------------------------------------------------------
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int ZERO_HI_MSB = 27;
    localparam int ZERO_HI_LSB = 24;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 8;
    localparam int CRC8_MSB = 7;
    localparam int CRC4_MSB = 3;

    // ----------------------------------------------------------------
    // polynomials and seeds
    // ----------------------------------------------------------------
    // x^8 + x^5 + x^3 + x^2 + x + 1, leading term implied
    localparam logic [7:0] CRC8_POLY = 8'h2F;
    // default 4-bit polynomial x^4 + x + 1, leading term implied
    localparam logic [3:0] CRC4_POLY_DEF = 4'h3;
    localparam logic [3:0] SEED_UPPER = 4'hF;
    localparam logic [7:0] SEED_ALL_ONES = 8'hFF;
    localparam logic [3:0] SEED_FIELD_ZERO = 4'h0;
    localparam logic [7:0] CRC_RESET = 8'h00;

    // seed for the shift register: nibble in its low bits under ones, all ones for a zero field; in 4-bit mode the bare nibble, zero for a zero field
    function automatic logic [7:0] seed_of(input logic [3:0] nib, input logic mode4);
        logic [7:0] s;
        s = (nib == SEED_FIELD_ZERO) ? SEED_ALL_ONES : {SEED_UPPER, nib};
        if (mode4)
        begin
            s = {4'h0, nib};
        end
        return s;
    endfunction : seed_of

endpackage : sfcc_pkg

// ### logic/sfcc_rx_deser.sv
// collects a 32-bit command frame from the serial line, msb first
// assumes start_i marks the frame start before its first bit
module sfcc_rx_deser (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic valid_i,
    input wire logic bit_i,
    output logic [31:0] frame_o,
    output logic full_o
);
    import sfcc_pkg::*;

    logic [31:0] frame;
    logic [5:0] count;
    logic take;

    // bits beyond the 32nd are dropped so the frame cannot smear
    assign take = valid_i && (count != FRAME_BITS_CNT);

    // shift register: earlier bits move toward bit 31
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            frame <= 32'h0000_0000;
        else if (take)
            frame <= {frame[30:0], bit_i};
    end

    // bit counter
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            count <= 6'h00;
        else if (start_i)
            count <= 6'h00;
        else if (take)
            count <= count + 6'h01;
    end

    assign frame_o = frame;
    assign full_o = (count == FRAME_BITS_CNT);
endmodule : sfcc_rx_deser

// ### logic/spi_frame_crc_check.sv
// spi frame crc checker top: checks commands, generates response crcs
// assumes serial bits arrive with a strobe synchronous to mclk_i
module spi_frame_crc_check #(
    parameter logic [3:0] CRC4_POLY = sfcc_pkg::CRC4_POLY_DEF
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic rx_frame_start_i,
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    input wire logic crc4_sel_i,
    input wire logic [3:0] crc_seed_nibble_i,
    input wire logic resp_start_i,
    input wire logic [31:0] resp_word_i,
    output logic [31:0] cmd_frame_o,
    output logic [3:0] cmd_code_o,
    output logic [7:0] target_reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic cmd_valid_o,
    output logic cmd_error_o,
    output logic error_resp_pend_o,
    output logic resp_busy_o,
    output logic [31:0] tx_frame_o,
    output logic tx_done_o
);
    import sfcc_pkg::*;

    typedef enum logic [1:0] {GEN_IDLE, GEN_SHIFT, GEN_FIN} sfcc_gen_state_t;

    sfcc_crc_if rx_crc_if ();
    sfcc_crc_if tx_crc_if ();

    logic [31:0] rx_frame;
    logic rx_full;
    logic rx_judged;
    logic rx_mode4;
    logic rx_judge;
    logic rx_zero;
    logic [7:0] cfg_seed;
    sfcc_gen_state_t gen_state;
    sfcc_gen_state_t next_gen_state;
    logic [4:0] gen_step;
    logic [31:0] gen_msg;
    logic gen_mode4;
    logic gen_accept;
    logic [4:0] gen_msg_len;
    logic gen_din;
    logic [4:0] gen_idx;
    logic [31:0] gen_frame;

    // ----------------------------------------------------------------
    // command receive path
    // ----------------------------------------------------------------
    sfcc_rx_deser u_rx_deser (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .start_i(rx_frame_start_i),
        .valid_i(rx_bit_valid_i),
        .bit_i(rx_bit_i),
        .frame_o(rx_frame),
        .full_o(rx_full)
    );

    sfcc_crc_serial #(.CRC4_POLY(CRC4_POLY)) u_rx_crc (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .crc_if(rx_crc_if)
    );

    // seed from the configuration nibble, width chosen by the mode select
    assign cfg_seed = seed_of(crc_seed_nibble_i, crc4_sel_i);
    // check engine: seed at frame start, then all 32 bits in arrival order
    assign rx_crc_if.load = rx_frame_start_i;
    assign rx_crc_if.seed = cfg_seed;
    assign rx_crc_if.shift = rx_bit_valid_i && !rx_full && !rx_frame_start_i;
    assign rx_crc_if.din = rx_bit_i;
    assign rx_crc_if.mode4 = rx_mode4;
    // crc field included, so a clean frame leaves nothing behind
    assign rx_zero = (rx_crc_if.crc == CRC_RESET);
    assign rx_judge = rx_full && !rx_judged;

    // mode latched per frame: a select change mid-frame cannot split a check
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_mode4 <= 1'b0;
        else if (rx_frame_start_i)
            rx_mode4 <= crc4_sel_i;
    end

    // one verdict per frame
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_judged <= 1'b0;
        else if (rx_frame_start_i)
            rx_judged <= 1'b0;
        else if (rx_judge)
            rx_judged <= 1'b1;
    end

    // verdict pulses; a failed frame never reaches the command side
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cmd_valid_o <= 1'b0;
            cmd_error_o <= 1'b0;
        end
        else
        begin
            cmd_valid_o <= rx_judge && rx_zero;
            cmd_error_o <= rx_judge && !rx_zero;
        end
    end

    // command fields only update on a good frame
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cmd_frame_o <= 32'h0000_0000;
        else if (rx_judge && rx_zero)
            cmd_frame_o <= rx_frame;
    end

    // same field slicing in both modes, only the crc width differs
    assign cmd_code_o = cmd_frame_o[CMD_MSB:CMD_LSB];
    assign target_reg_addr_o = cmd_frame_o[ADDR_MSB:ADDR_LSB];
    assign reg_wdata_o = cmd_frame_o[DATA_MSB:DATA_LSB];

    // pending error response; a new failure beats the clear by a response
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            error_resp_pend_o <= 1'b0;
        else if (rx_judge && !rx_zero)
            error_resp_pend_o <= 1'b1;
        else if (gen_accept)
            error_resp_pend_o <= 1'b0;
    end

    // ----------------------------------------------------------------
    // response crc generation
    // ----------------------------------------------------------------
    sfcc_crc_serial #(.CRC4_POLY(CRC4_POLY)) u_tx_crc (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .crc_if(tx_crc_if)
    );

    // requests while busy are ignored, the word is latched on acceptance
    assign gen_accept = resp_start_i && (gen_state == GEN_IDLE);
    assign resp_busy_o = (gen_state != GEN_IDLE);
    assign gen_msg_len = gen_mode4 ? MSG_LEN_CRC4 : MSG_LEN_CRC8;
    assign gen_idx = LAST_BIT_IDX - gen_step;
    // message bits msb first, then zeros to fill the crc length
    assign gen_din = (gen_step < gen_msg_len) ? gen_msg[gen_idx] : 1'b0;
    // both modes take exactly 32 shifts: 24 + 8 or 28 + 4
    assign tx_crc_if.load = gen_accept;
    assign tx_crc_if.seed = cfg_seed;
    assign tx_crc_if.shift = (gen_state == GEN_SHIFT);
    assign tx_crc_if.din = gen_din;
    assign tx_crc_if.mode4 = gen_mode4;
    // register contents after the last zero become the crc field
    assign gen_frame = gen_mode4 ? {gen_msg[31:4], tx_crc_if.crc[CRC4_MSB:0]}
                                 : {gen_msg[31:8], tx_crc_if.crc};

    // generator sequence
    always_comb
    begin
        next_gen_state = gen_state;
        case (gen_state)
            GEN_IDLE:
                if (resp_start_i)
                    next_gen_state = GEN_SHIFT;
            GEN_SHIFT:
                if (gen_step == LAST_STEP)
                    next_gen_state = GEN_FIN;
            GEN_FIN:
                next_gen_state = GEN_IDLE;
            default:
                next_gen_state = GEN_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gen_state <= GEN_IDLE;
        else
            gen_state <= next_gen_state;
    end

    // step counter runs over message and padding together
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gen_step <= 5'h00;
        else if (gen_accept)
            gen_step <= 5'h00;
        else if (gen_state == GEN_SHIFT)
            gen_step <= gen_step + 5'h01;
    end

    // captured response word and its mode
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            gen_msg <= 32'h0000_0000;
            gen_mode4 <= 1'b0;
        end
        else if (gen_accept)
        begin
            gen_msg <= resp_word_i;
            gen_mode4 <= crc4_sel_i;
        end
    end

    // finished frame and its done pulse
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_frame_o <= 32'h0000_0000;
        else if (gen_state == GEN_FIN)
            tx_frame_o <= gen_frame;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_done_o <= 1'b0;
        else
            tx_done_o <= (gen_state == GEN_FIN);
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    seed_load_a: assert property (
        rx_frame_start_i && !crc4_sel_i && (crc_seed_nibble_i == 4'h0)
        |=> rx_crc_if.crc == 8'hFF)
        else $error("zero seed field did not load all ones");

    seed_nibble_a: assert property (
        rx_frame_start_i && !crc4_sel_i && (crc_seed_nibble_i != 4'h0)
        |=> rx_crc_if.crc == {4'hF, $past(crc_seed_nibble_i)})
        else $error("nonzero seed field loaded wrong seed");

    msb_order_a: assert property (
        rx_crc_if.shift |=> u_rx_deser.frame_o[0] == $past(rx_bit_i))
        else $error("received bit not taken into lsb");

    poly_step_a: assert property (
        rx_crc_if.shift && !rx_mode4
        |=> rx_crc_if.crc == ({$past(rx_crc_if.crc[6:0]), $past(rx_bit_i)}
            ^ ($past(rx_crc_if.crc[7]) ? 8'h2F : 8'h00)))
        else $error("crc step does not match polynomial");

    good_verdict_a: assert property (
        rx_judge |=> (cmd_valid_o == $past(rx_zero)) && (cmd_error_o == !$past(rx_zero)))
        else $error("verdict does not follow the zero test");

    drop_bad_a: assert property (
        cmd_error_o |-> !cmd_valid_o && $stable(cmd_frame_o) && error_resp_pend_o)
        else $error("failed command not dropped");

    field_map_a: assert property (
        cmd_valid_o |-> cmd_frame_o == $past(rx_frame)
            && target_reg_addr_o == $past(rx_frame[23:16])
            && reg_wdata_o == $past(rx_frame[15:8]) && cmd_code_o == $past(rx_frame[31:28]))
        else $error("command fields sliced wrongly");

    gen_length_a: assert property (
        gen_accept |-> ##34 tx_done_o)
        else $error("response crc not ready 34 cycles after start");

    gen_zero_pad_a: assert property (
        tx_crc_if.shift && !gen_mode4 && (gen_step >= 5'h18) |-> !tx_crc_if.din)
        else $error("padding bit not zero");

    gen_keep_msg_a: assert property (
        tx_done_o && !gen_mode4 |-> tx_frame_o[31:8] == gen_msg[31:8])
        else $error("response message bits altered");

    one_verdict_a: assert property (
        rx_judge |=> !rx_judge)
        else $error("frame judged twice");

    good_cmd_c: cover property (cmd_valid_o);
    bad_cmd_c: cover property (cmd_error_o);
    tx_crc4_c: cover property (tx_done_o && gen_mode4);
    rx_crc4_c: cover property (cmd_valid_o && rx_mode4);
endmodule : spi_frame_crc_check

// ### verification/sfcc_host_model.sv
// host-side model: sends 32-bit command frames msb first, with its own crc
// assumes the bench calls its tasks and the checker samples on rising edges
module sfcc_host_model #(
    parameter logic [3:0] CRC4_POLY = sfcc_pkg::CRC4_POLY_DEF
) (
    input wire logic mclk_i,
    output logic rx_frame_start_o,
    output logic rx_bit_valid_o,
    output logic rx_bit_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // crc, built the same way as on the device side
    // ------------------------------------------------------------
    // message bits then zero padding; no pull on the line, so idle shows ~last
    function automatic logic [7:0] crc_of(input logic [31:0] w, input logic m4,
                                          input logic [3:0] nib);
        logic [7:0] r;
        logic d;
        int i;
        r = m4 ? {4'h0, nib} : ((nib == 4'h0) ? 8'hFF : {4'hF, nib});
        // each bit rotates into the lsb; the bit pushed out of the top folds the polynomial
        for (i = 31; i >= 0; i--)
        begin
            d = (i >= (m4 ? 4 : 8)) ? w[i] : 1'b0;
            if (m4)
                r = {4'h0, r[2:0], d} ^ (r[3] ? {4'h0, CRC4_POLY} : 8'h00);
            else
                r = {r[6:0], d} ^ (r[7] ? 8'h2F : 8'h00);
        end
        return m4 ? {4'h0, r[3:0]} : r;
    endfunction : crc_of

    // inserts the crc field; bad flips the lowest crc bit on purpose
    function automatic logic [31:0] framed(input logic [31:0] w, input logic m4,
                                           input logic [3:0] nib, input logic bad);
        logic [7:0] c;
        c = crc_of(w, m4, nib) ^ {7'h00, bad};
        return m4 ? {w[31:4], c[3:0]} : {w[31:8], c};
    endfunction : framed

    initial
    begin
        rx_frame_start_o = 1'b0;
        rx_bit_valid_o = 1'b0;
        rx_bit_o = 1'b0;
    end

    // ------------------------------------------------------------
    // serial sender
    // ------------------------------------------------------------
    // gap idles the strobe between bits to act as a slow host
    task automatic send(input logic [31:0] w, input int gap);
        int i;
        int g;
        @(negedge mclk_i);
        rx_frame_start_o = 1'b1;
        rx_bit_o = ~rx_bit_o;
        for (i = 31; i >= 0; i--)
        begin
            @(negedge mclk_i);
            rx_frame_start_o = 1'b0;
            rx_bit_valid_o = 1'b1;
            rx_bit_o = w[i];
            // no idle after the last bit, so the verdict timing stays fixed
            for (g = 0; g < gap && i > 0; g++)
            begin
                @(negedge mclk_i);
                rx_bit_valid_o = 1'b0;
                rx_bit_o = ~rx_bit_o;
            end
        end
        @(negedge mclk_i);
        rx_bit_valid_o = 1'b0;
        rx_bit_o = ~rx_bit_o;
    endtask : send
endmodule : sfcc_host_model

// ### verification/test_spi_frame_crc_check.sv
// self-checking bench for the spi frame crc checker
// assumes the host model file and the design files are compiled first
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_spi_frame_crc_check;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic crc4_sel_i = 1'b0;
    logic [3:0] crc_seed_nibble_i = 4'h0;
    logic resp_start_i = 1'b0;
    logic [31:0] resp_word_i = 32'h0000_0000;
    logic rx_frame_start_i;
    logic rx_bit_valid_i;
    logic rx_bit_i;
    logic [31:0] cmd_frame_o;
    logic [3:0] cmd_code_o;
    logic [7:0] target_reg_addr_o;
    logic [7:0] reg_wdata_o;
    logic cmd_valid_o;
    logic cmd_error_o;
    logic error_resp_pend_o;
    logic resp_busy_o;
    logic [31:0] tx_frame_o;
    logic tx_done_o;
    logic [31:0] last_good = 32'h0000_0000;
    int miscompares = 0;
    int checks_done = 0;
    // known-good frames: command, address, data, crc with the all-ones seed
    logic [31:0] table8 [7] = '{32'h8022_C1BD, 32'h401F_C157, 32'hC022_0066,
        32'h601F_C1B8, 32'h40FF_5AE5, 32'hC03E_0013, 32'h60FF_5A0A};

    always #12.5 mclk_i = ~mclk_i;

    sfcc_host_model host (
        .mclk_i(mclk_i),
        .rx_frame_start_o(rx_frame_start_i),
        .rx_bit_valid_o(rx_bit_valid_i),
        .rx_bit_o(rx_bit_i)
    );

    spi_frame_crc_check dut (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .rx_frame_start_i(rx_frame_start_i),
        .rx_bit_valid_i(rx_bit_valid_i),
        .rx_bit_i(rx_bit_i),
        .crc4_sel_i(crc4_sel_i),
        .crc_seed_nibble_i(crc_seed_nibble_i),
        .resp_start_i(resp_start_i),
        .resp_word_i(resp_word_i),
        .cmd_frame_o(cmd_frame_o),
        .cmd_code_o(cmd_code_o),
        .target_reg_addr_o(target_reg_addr_o),
        .reg_wdata_o(reg_wdata_o),
        .cmd_valid_o(cmd_valid_o),
        .cmd_error_o(cmd_error_o),
        .error_resp_pend_o(error_resp_pend_o),
        .resp_busy_o(resp_busy_o),
        .tx_frame_o(tx_frame_o),
        .tx_done_o(tx_done_o)
    );

    // ------------------------------------------------------------
    // shared steps
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // sends one frame and judges the single verdict pulse one cycle later
    task automatic frame(input logic [31:0] w, input logic good, input int gap);
        int n;
        host.send(w, gap);
        n = 0;
        while (cmd_valid_o !== 1'b1 && cmd_error_o !== 1'b1 && n < 10)
        begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("verdict delay", 1, n)
        `CHK("cmd valid", good, cmd_valid_o)
        `CHK("cmd error", ~good, cmd_error_o)
        if (good)
            last_good = w;
        else
            `CHK("error pending", 1'b1, error_resp_pend_o)
        `CHK("cmd frame", last_good, cmd_frame_o)
        `CHK("target addr", last_good[23:16], target_reg_addr_o)
        `CHK("write data", last_good[15:8], reg_wdata_o)
        `CHK("cmd code", last_good[31:28], cmd_code_o)
        @(negedge mclk_i);
        `CHK("error pulse", 1'b0, cmd_error_o)
    endtask : frame

    // response crc; a start while busy must be ignored
    task automatic resp(input logic [31:0] w, input logic m4, input logic [31:0] exp);
        int n;
        @(negedge mclk_i);
        crc4_sel_i = m4;
        resp_word_i = w;
        resp_start_i = 1'b1;
        for (n = 1; n <= 40; n++)
        begin
            @(negedge mclk_i);
            resp_start_i = (n == 4);
            if (n == 1)
                `CHK("busy", 1'b1, resp_busy_o)
            if (tx_done_o === 1'b1)
                break;
        end
        `CHK("tx latency", 34, n)
        `CHK("tx frame", exp, tx_frame_o)
        `CHK("error pending", 1'b0, error_resp_pend_o)
    endtask : resp

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        `CHK("valid at reset", 1'b0, cmd_valid_o)
        `CHK("busy at reset", 1'b0, resp_busy_o)
        `CHK("frame at reset", 32'h0000_0000, cmd_frame_o)
    endtask : t_reset

    // back-to-back known frames, then corrupted ones
    task automatic t_table8;
        int i;
        for (i = 0; i < 7; i++)
            frame(table8[i], 1'b1, 0);
        frame(table8[0] ^ 32'h0000_0001, 1'b0, 0);
        frame(table8[1] ^ 32'h8000_0000, 1'b0, 0);
    endtask : t_table8

    // nonzero seed field with a slow host
    task automatic t_seed;
        crc_seed_nibble_i = 4'h5;
        frame(host.framed(32'h3012_A500, 1'b0, 4'h5, 1'b0), 1'b1, 2);
        frame(host.framed(32'h3012_A500, 1'b0, 4'h0, 1'b0), 1'b0, 1);
        crc_seed_nibble_i = 4'h0;
    endtask : t_seed

    // 4-bit mode: register and sensor-data frames, good and bad
    task automatic t_crc4;
        crc4_sel_i = 1'b1;
        crc_seed_nibble_i = 4'hA;
        frame(host.framed(32'h2045_6700, 1'b1, 4'hA, 1'b0), 1'b1, 0);
        frame(host.framed(32'h1000_0000, 1'b1, 4'hA, 1'b0), 1'b1, 1);
        frame(host.framed(32'h2045_6700, 1'b1, 4'hA, 1'b1), 1'b0, 0);
        crc_seed_nibble_i = 4'h0;
        frame(host.framed(32'hE0FF_0100, 1'b1, 4'h0, 1'b0), 1'b1, 0);
        crc4_sel_i = 1'b0;
    endtask : t_crc4

    task automatic t_resp;
        resp(32'h8022_C100, 1'b0, 32'h8022_C1BD);
        crc_seed_nibble_i = 4'h7;
        resp(32'h1234_56FF, 1'b0, host.framed(32'h1234_56FF, 1'b0, 4'h7, 1'b0));
        resp(32'h1234_56FF, 1'b1, host.framed(32'h1234_56FF, 1'b1, 4'h7, 1'b0));
        crc_seed_nibble_i = 4'h0;
    endtask : t_resp

    // a hang counts as a mismatch and ends in the same report
    initial
    begin
        #2ms;
        miscompares++;
        final_report();
    end

    initial
    begin
        repeat (16) @(negedge mclk_i);
        arst_n_i = 1'b1;
        @(negedge mclk_i);
        t_reset();
        t_table8();
        t_seed();
        t_crc4();
        frame(table8[2] ^ 32'h0001_0000, 1'b0, 0);
        t_resp();
        final_report();
    end
endmodule : test_spi_frame_crc_check
